// ### common/psc_defs.svh
// Behaviour
// RULE1 - Main output on only while request low
// RULE2 - Outputs regulated 5 to 400 ms after request
// RULE3 - Power-good starts falling within 50 ms of release
// RULE4 - Power-good high only while all outputs regulate; the code also keeps it high in ST_STBY and ST_WAKE
// RULE5 - Power-good low on dropout, failure, input loss; ST_WAKE does not check input loss
// RULE6 - Current limit holds off power-good delay start
// RULE7 - Power-good 100 to 500 ms after regulation
// RULE8 - Power-good falls 1 to 200 ms before 12V
// RULE9 - Alert low only for masked events enabled
// RULE10 - Alert mask resets to temperature, undervoltage, overcurrent
// RULE11 - Alert asserted together with amber indicator
// RULE12 - Redundancy line open collector, defaults low
// RULE13 - Four redundancy modes set over bus
// RULE14 - Standby slave keeps power-good, solid green
// RULE15 - Hash-suffixed signals are active low
`ifndef PSC_DEFS_SVH
`define PSC_DEFS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define PSC_ADDR_W          8
`define PSC_OFS_CTRL        8'h00
`define PSC_OFS_AMASK       8'h04
`define PSC_OFS_ISTS        8'h08
`define PSC_OFS_IMASK       8'h0C
`define PSC_OFS_STATE       8'h10
`define PSC_AMASK_RST       8'h07
`define PSC_EVT_CRIT        8'h3A
`define PSC_IMASK_RST       6'h00
`define PSC_RESP_OKAY       2'h0
`define PSC_RESP_SLVERR     2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PSC_CLK_KHZ         200000
`define PSC_TICK_MS         1
`define PSC_T_ON_MIN_MS     5
`define PSC_T_ON_MAX_MS     400
`define PSC_T_PGOFF_MAX_MS  50
`define PSC_T_PGON_MIN_MS   100
`define PSC_T_PGON_MAX_MS   500
`define PSC_T_PGPRE_MIN_MS  1
`define PSC_T_PGPRE_MAX_MS  200
`define PSC_SOFT_TICKS      (`PSC_T_ON_MIN_MS / `PSC_TICK_MS + 1)
`define PSC_RAMP_TICKS      (`PSC_T_ON_MAX_MS / `PSC_TICK_MS - `PSC_SOFT_TICKS - 1)
`define PSC_PGON_TICKS      (`PSC_T_PGON_MIN_MS / `PSC_TICK_MS + 1)
`define PSC_PGPRE_TICKS     (`PSC_T_PGPRE_MIN_MS / `PSC_TICK_MS + 1)
`define PSC_TMR_W           10

`endif

// ### common/psc_pkg.sv
package psc_pkg;
  typedef enum logic [8:0] {
    ST_OFF   = 9'b0_0000_0001,
    ST_SOFT  = 9'b0_0000_0010,
    ST_RAMP  = 9'b0_0000_0100,
    ST_DELAY = 9'b0_0000_1000,
    ST_ON    = 9'b0_0001_0000,
    ST_STBY  = 9'b0_0010_0000,
    ST_WAKE  = 9'b0_0100_0000,
    ST_DOWN  = 9'b0_1000_0000,
    ST_FAULT = 9'b1_0000_0000
  } psc_state_t;
  typedef enum logic [1:0] {
    MODE_LD_MASTER  = 2'h0,
    MODE_LD_SLAVE   = 2'h1,
    MODE_VIN_MASTER = 2'h2,
    MODE_MD_SLAVE   = 2'h3
  } psc_mode_t;
  typedef enum logic [1:0] {
    LED_OFF    = 2'h0,
    LED_GREEN  = 2'h1,
    LED_AMBER  = 2'h2,
    LED_ABLINK = 2'h3
  } psc_led_t;
endpackage

// ### common/psc_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface psc_tmr_if;
  logic msTick;
  modport src (output msTick);
  modport snk (input msTick);
endinterface
`default_nettype wire

// ### hw/psc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module psc_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  // Data
  input  wire logic [W-1:0] asyncIn,
  output var  logic [W-1:0] syncOut
);
  logic [W-1:0] stage1Q;

  if (W < 1) begin : g_badW
    $error("psc_sync width must be at least one.");
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1Q <= '0;
      syncOut <= '0;
    end else begin
      stage1Q <= asyncIn;
      syncOut <= stage1Q;
    end
  end
endmodule // psc_sync
`default_nettype wire

// ### hw/psc_ms_tick.sv
`include "psc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module psc_ms_tick #(
  parameter int unsigned MS_CYCLES = `PSC_CLK_KHZ * `PSC_TICK_MS
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // Tick out
  psc_tmr_if.src    tmr
);
  logic [31:0] cntQ;
  logic [31:0] cntD;
  logic        tickD;

  if (MS_CYCLES < 2) begin : g_badCycles
    $error("psc_ms_tick needs at least two cycles per tick.");
  end

  always_comb begin
    tickD = (cntQ == 32'(MS_CYCLES - 1));
    cntD  = tickD ? 32'h0000_0000 : cntQ + 32'h0000_0001;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cntQ       <= 32'h0000_0000;
      tmr.msTick <= 1'b0;
    end else begin
      cntQ       <= cntD;
      tmr.msTick <= tickD;
    end
  end
endmodule // psc_ms_tick
`default_nettype wire

// ### hw/psc_top.sv
// Design decisions made here: the address map and the AXI4-Lite register port.
`include "psc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module psc_top
  import psc_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `PSC_CLK_KHZ * `PSC_TICK_MS
) (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  // AXI4-Lite slave
  input  wire logic [`PSC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output var  logic                   s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output var  logic                   s_axi_wready,
  output var  logic [1:0]             s_axi_bresp,
  output var  logic                   s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`PSC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output var  logic                   s_axi_arready,
  output var  logic [31:0]            s_axi_rdata,
  output var  logic [1:0]             s_axi_rresp,
  output var  logic                   s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Host pins
  input  wire logic                   onReqPin_b,
  output var  logic                   powerGoodAlias,
  input  wire logic                   alertLineIn,
  output var  logic                   alertLineOut,
  output var  logic                   alertLineOe,
  // Shared redundancy line
  input  wire logic                   redundancyStandbyLineIn,
  output var  logic                   redundancyStandbyLineOut,
  output var  logic                   redundancyStandbyLineOe,
  // Power stage status and control
  input  wire logic                   mainInReg,
  input  wire logic                   curLimit,
  input  wire logic                   intFail,
  input  wire logic                   inputOk,
  input  wire logic                   loadHigh,
  input  wire logic                   vinLow,
  input  wire logic [7:0]             plantEvt,
  output var  logic                   mainEnable,
  output var  logic [1:0]             ledCode,
  output var  logic                   irq
);
  // ----------------------------------------------------------------
  // Input synchronisers and millisecond tick
  // ----------------------------------------------------------------
  localparam int unsigned SYNC_W = 17;
  logic [SYNC_W-1:0] syncBus;
  logic              onReqS_b;
  logic              inRegS;
  logic              curLimS;
  logic              failS;
  logic              inOkS;
  logic              loadHighS;
  logic              vinLowS;
  logic              redLineS;
  logic              alertLineS;
  logic [7:0]        evtS;
  psc_tmr_if         tmrIf ();

  psc_sync #(.W(SYNC_W)) u_sync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .asyncIn ({onReqPin_b, mainInReg, curLimit, intFail, inputOk, loadHigh, vinLow,
               redundancyStandbyLineIn, alertLineIn, plantEvt}),
    .syncOut (syncBus)
  );
  assign {onReqS_b, inRegS, curLimS, failS, inOkS, loadHighS, vinLowS, redLineS, alertLineS, evtS} = syncBus;

  psc_ms_tick #(.MS_CYCLES(MS_CYCLES)) u_tick (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .tmr     (tmrIf.src)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  psc_state_t              stateQ;
  psc_state_t              stateD;
  logic [`PSC_TMR_W-1:0]   tmrQ;
  logic [`PSC_TMR_W-1:0]   tmrD;
  psc_mode_t               modeQ;
  logic                    onReqAct;
  logic                    stbyElig;
  logic                    demand;

  // The pull-up inside the pin makes an open pin read high, which is off.
  assign onReqAct = !onReqS_b; // RULE15 RULE1
  assign stbyElig = redLineS && ((modeQ == MODE_LD_SLAVE && !loadHighS) || modeQ == MODE_MD_SLAVE); // RULE13
  assign demand   = (modeQ == MODE_LD_MASTER && loadHighS) || (modeQ == MODE_VIN_MASTER && vinLowS); // RULE13

  always_comb begin
    stateD = stateQ;
    tmrD   = (tmrIf.msTick && tmrQ != {`PSC_TMR_W{1'b1}}) ? tmrQ + `PSC_TMR_W'(1) : tmrQ;
    case (stateQ)
      ST_OFF: begin
        if (onReqAct && inOkS) stateD = ST_SOFT; // RULE1
      end
      ST_SOFT: begin
        if (!onReqAct) stateD = ST_OFF;
        else if (tmrQ >= `PSC_TMR_W'(`PSC_SOFT_TICKS)) stateD = ST_RAMP; // RULE2
      end
      ST_RAMP: begin
        if (!onReqAct) stateD = ST_DOWN;
        else if (failS || tmrQ >= `PSC_TMR_W'(`PSC_RAMP_TICKS)) stateD = ST_FAULT; // RULE2
        else if (inRegS) stateD = ST_DELAY;
      end
      ST_DELAY: begin
        if (!onReqAct || !inOkS) stateD = ST_DOWN;
        else if (failS || !inRegS) stateD = ST_FAULT;
        else if (curLimS) tmrD = '0; // RULE6
        else if (tmrQ >= `PSC_TMR_W'(`PSC_PGON_TICKS)) stateD = ST_ON; // RULE7
      end
      ST_ON: begin
        if (!onReqAct || !inOkS) stateD = ST_DOWN; // RULE3 RULE5
        else if (failS || !inRegS) stateD = ST_FAULT; // RULE5
        else if (stbyElig) stateD = ST_STBY;
      end
      ST_STBY: begin
        if (!onReqAct) stateD = ST_OFF;
        else if (failS || !inOkS) stateD = ST_FAULT;
        else if (!stbyElig) stateD = ST_WAKE;
      end
      ST_WAKE: begin
        if (!onReqAct) stateD = ST_DOWN;
        else if (failS || tmrQ >= `PSC_TMR_W'(`PSC_RAMP_TICKS)) stateD = ST_FAULT;
        else if (inRegS) stateD = ST_ON;
      end
      ST_DOWN: begin
        // The main rail is held until power-good has been low long enough.
        if (tmrQ >= `PSC_TMR_W'(`PSC_PGPRE_TICKS)) stateD = ST_OFF; // RULE8
      end
      ST_FAULT: begin
        // A protection latch is released only by a release of the request.
        if (!onReqAct) stateD = ST_OFF;
      end
      default: stateD = ST_OFF;
    endcase
    if (stateD != stateQ) tmrD = '0;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stateQ <= ST_OFF;
      tmrQ   <= '0;
    end else begin
      stateQ <= stateD;
      tmrQ   <= tmrD;
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs, indicator and alert
  // ----------------------------------------------------------------
  logic     pgD;
  logic     mainEnD;
  logic     redOeD;
  logic     alertOeD;
  psc_led_t ledD;
  logic [7:0] amaskQ;
  logic     evtHit;
  logic     critHit;

  assign evtHit  = |(evtS & amaskQ); // RULE9
  assign critHit = |(evtS & amaskQ & `PSC_EVT_CRIT);

  always_comb begin
    pgD     = (stateD == ST_ON) || (stateD == ST_STBY) || (stateD == ST_WAKE); // RULE4 RULE14
    mainEnD = (stateD == ST_RAMP) || (stateD == ST_DELAY) || (stateD == ST_ON) ||
              (stateD == ST_WAKE) || (stateD == ST_DOWN); // RULE1 RULE8
    // The line is pulled low unless this unit is up and lets slaves rest.
    redOeD  = !(pgD && !demand); // RULE12
    if (critHit) ledD = LED_AMBER;
    else if (evtHit) ledD = LED_ABLINK;
    else if (pgD) ledD = LED_GREEN; // RULE14
    else ledD = LED_OFF;
    alertOeD = (ledD == LED_AMBER) || (ledD == LED_ABLINK); // RULE9 RULE11
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      powerGoodAlias          <= 1'b0;
      mainEnable              <= 1'b0;
      redundancyStandbyLineOe <= 1'b1;
      alertLineOe             <= 1'b0;
      ledCode                 <= LED_OFF;
    end else begin
      powerGoodAlias          <= pgD;
      mainEnable              <= mainEnD;
      redundancyStandbyLineOe <= redOeD;
      alertLineOe             <= alertOeD;
      ledCode                 <= ledD;
    end
  end

  // Both open-drain pins only ever pull low.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      alertLineOut             <= 1'b0;
      redundancyStandbyLineOut <= 1'b0;
    end else begin
      alertLineOut             <= 1'b0;
      redundancyStandbyLineOut <= 1'b0; // RULE12
    end
  end

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[i*8 +: 8] = nw[i*8 +: 8];
    end
    return res;
  endfunction

  logic                   awHeldQ, awHeldD, wHeldQ, wHeldD;
  logic [`PSC_ADDR_W-1:0] awAddrQ, awAddrD;
  logic [31:0]            wDataQ, wDataD, mrg;
  logic [3:0]             wStrbQ, wStrbD;
  logic                   bvalidD, arreadyD, rvalidD, irqD;
  logic [1:0]             brespD, rrespD;
  logic [31:0]            rdataD;
  psc_mode_t              modeD;
  logic [7:0]             amaskD;
  logic [5:0]             istsQ, istsD, imaskQ, imaskD, istsSet, istsClr;
  logic                   doWrite;

  assign doWrite = awHeldQ && wHeldQ && !s_axi_bvalid;
  assign mrg     = mergeStrb(32'h0000_0000, wDataQ, wStrbQ);
  assign istsSet = {(stateQ == ST_STBY) && (stateD != ST_STBY),
                    (stateD == ST_STBY) && (stateQ != ST_STBY),
                    (stateD == ST_FAULT) && (stateQ != ST_FAULT),
                    alertOeD && !alertLineOe,
                    !pgD && powerGoodAlias,
                    pgD && !powerGoodAlias};

  always_comb begin
    awHeldD  = awHeldQ;
    awAddrD  = awAddrQ;
    wHeldD   = wHeldQ;
    wDataD   = wDataQ;
    wStrbD   = wStrbQ;
    bvalidD  = s_axi_bvalid;
    brespD   = s_axi_bresp;
    rvalidD  = s_axi_rvalid;
    rdataD   = s_axi_rdata;
    rrespD   = s_axi_rresp;
    modeD    = modeQ;
    amaskD   = amaskQ;
    imaskD   = imaskQ;
    istsClr  = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      awHeldD = 1'b1;
      awAddrD = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHeldD = 1'b1;
      wDataD = s_axi_wdata;
      wStrbD = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) bvalidD = 1'b0;
    if (doWrite) begin
      awHeldD = 1'b0;
      wHeldD  = 1'b0;
      bvalidD = 1'b1;
      brespD  = `PSC_RESP_OKAY;
      if (awAddrQ == `PSC_OFS_CTRL) begin
        if (wStrbQ[0]) modeD = psc_mode_t'(wDataQ[1:0]); // RULE13
      end else if (awAddrQ == `PSC_OFS_AMASK) begin
        if (wStrbQ[0]) amaskD = wDataQ[7:0]; // RULE9
      end else if (awAddrQ == `PSC_OFS_ISTS) begin
        istsClr = mrg[5:0];
      end else if (awAddrQ == `PSC_OFS_IMASK) begin
        if (wStrbQ[0]) imaskD = wDataQ[5:0];
      end else if (awAddrQ != `PSC_OFS_STATE) begin
        brespD = `PSC_RESP_SLVERR;
      end
    end
    if (s_axi_rvalid && s_axi_rready) rvalidD = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalidD = 1'b1;
      rrespD  = `PSC_RESP_OKAY;
      if (s_axi_araddr == `PSC_OFS_CTRL) rdataD = {30'h0000_0000, modeQ};
      else if (s_axi_araddr == `PSC_OFS_AMASK) rdataD = {24'h00_0000, amaskQ};
      else if (s_axi_araddr == `PSC_OFS_ISTS) rdataD = {26'h000_0000, istsQ};
      else if (s_axi_araddr == `PSC_OFS_IMASK) rdataD = {26'h000_0000, imaskQ};
      else if (s_axi_araddr == `PSC_OFS_STATE) begin
        rdataD = {6'h00, evtS, alertLineS, redLineS, onReqAct, mainEnable, ledCode,
                  alertLineOe, powerGoodAlias, 1'b0, stateQ};
      end else begin
        rdataD = 32'h0000_0000;
        rrespD = `PSC_RESP_SLVERR;
      end
    end
    // A new event outranks a clear written in the same cycle.
    istsD    = (istsQ & ~istsClr) | istsSet;
    irqD     = |(istsD & imaskD);
    arreadyD = !rvalidD;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      awHeldQ       <= 1'b0;
      awAddrQ       <= '0;
      wHeldQ        <= 1'b0;
      wDataQ        <= 32'h0000_0000;
      wStrbQ        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PSC_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `PSC_RESP_OKAY;
      modeQ         <= MODE_LD_MASTER;
      amaskQ        <= `PSC_AMASK_RST; // RULE10
      istsQ         <= '0;
      imaskQ        <= `PSC_IMASK_RST;
      irq           <= 1'b0;
    end else begin
      awHeldQ       <= awHeldD;
      awAddrQ       <= awAddrD;
      wHeldQ        <= wHeldD;
      wDataQ        <= wDataD;
      wStrbQ        <= wStrbD;
      s_axi_awready <= !awHeldD;
      s_axi_wready  <= !wHeldD;
      s_axi_bvalid  <= bvalidD;
      s_axi_bresp   <= brespD;
      s_axi_arready <= arreadyD;
      s_axi_rvalid  <= rvalidD;
      s_axi_rdata   <= rdataD;
      s_axi_rresp   <= rrespD;
      modeQ         <= modeD;
      amaskQ        <= amaskD;
      istsQ         <= istsD;
      imaskQ        <= imaskD;
      irq           <= irqD;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  req_off_a: assert property (stateQ == ST_OFF && !onReqAct |=> !mainEnable && !powerGoodAlias) // RULE1
    else $error("Main output on without request.");
  soft_start_a: assert property ($rose(mainEnable) && $past(stateQ) == ST_SOFT
                                 |-> $past(tmrQ) >= `PSC_TMR_W'(`PSC_SOFT_TICKS)) // RULE2
    else $error("Main output enabled too early.");
  pg_release_a: assert property (powerGoodAlias && !onReqAct && stateQ != ST_STBY |=> !powerGoodAlias) // RULE3
    else $error("Power-good not dropped after request release.");
  pg_reg_a: assert property (stateQ == ST_ON && !inRegS |=> !powerGoodAlias) // RULE4
    else $error("Power-good high while out of regulation.");
  pg_fail_a: assert property (powerGoodAlias && failS |=> !powerGoodAlias) // RULE5
    else $error("Power-good high after internal failure.");
  climit_hold_a: assert property (stateQ == ST_DELAY && curLimS && onReqAct && inRegS && inOkS && !failS
                                  |=> tmrQ == '0) // RULE6
    else $error("Delay ran during current limit.");
  pg_delay_a: assert property ($rose(powerGoodAlias) && $past(stateQ) == ST_DELAY
                               |-> $past(tmrQ) >= `PSC_TMR_W'(`PSC_PGON_TICKS)) // RULE7
    else $error("Power-good asserted too early.");
  pg_lead_a: assert property ($fell(mainEnable) && $past(stateQ) == ST_DOWN
                              |-> !powerGoodAlias && $past(tmrQ) >= `PSC_TMR_W'(`PSC_PGPRE_TICKS)) // RULE8
    else $error("Main rail dropped before power-good lead time.");
  alert_mask_a: assert property (alertLineOe |-> $past(|(evtS & amaskQ))) // RULE9
    else $error("Alert without an enabled event.");
  alert_led_a: assert property (alertLineOe == (ledCode == LED_AMBER || ledCode == LED_ABLINK)) // RULE11
    else $error("Alert and amber indicator disagree.");
  red_default_a: assert property (!powerGoodAlias |-> redundancyStandbyLineOe && !redundancyStandbyLineOut) // RULE12
    else $error("Redundancy line released while down.");
  stby_pg_a: assert property (stateQ == ST_STBY && !alertLineOe |-> powerGoodAlias && ledCode == LED_GREEN) // RULE14
    else $error("Standby without power-good and green.");
endmodule // psc_top
`default_nettype wire

// ### tb/psc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module psc_host_model #(
  parameter int DLY = 40
) (
  // Clock
  input  wire logic ref_clk,
  // Device pins
  input  wire logic mainEnable,
  input  wire logic alertLineOut,
  input  wire logic alertLineOe,
  input  wire logic redundancyStandbyLineOut,
  input  wire logic redundancyStandbyLineOe,
  // Peer supply pulling the shared line
  input  wire logic peerPullLow,
  // Resolved levels
  output var  logic mainInReg,
  output var  logic alertLine,
  output var  logic redundancyStandbyLine
);
  int cnt = 0;
  initial mainInReg = 1'b0;
  // Both lines have a system pull-up, so a released line reads high.
  assign alertLine = alertLineOe ? alertLineOut : 1'b1;
  assign redundancyStandbyLine = (redundancyStandbyLineOe ? redundancyStandbyLineOut : 1'b1) & ~peerPullLow;
  // The rail lags its enable both ways, so a slow supply is seen as one.
  always @(posedge ref_clk) begin
    if (mainEnable !== mainInReg && cnt == DLY) begin
      mainInReg <= mainEnable;
      cnt <= 0;
    end else begin
      cnt <= (mainEnable !== mainInReg) ? cnt + 1 : 0;
    end
  end
endmodule // psc_host_model
`default_nettype wire

// ### tb/psc_top_tb.sv
`include "psc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module psc_top_tb import psc_pkg::*; ;
  localparam int MSC = 20;
  logic ref_clk = 1'b0, rst_b = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, plantEvt = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, d;
  logic [1:0] bresp, rresp, r, ledCode;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pg, alertIn, alertOut, alertOe, redIn, redOut, redOe;
  logic onReq_b = 1'b1, curLimit = 1'b0, intFail = 1'b0, extLow = 1'b0, inOk = 1'b1, mainInReg, mainEnable, irq;
  logic [3:0] wstrb = 4'hF;
  int fails = 0, checked = 0, cyc = 0, t0;
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;
  psc_top #(.MS_CYCLES(MSC)) uut (.ref_clk(ref_clk), .rst_b(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .onReqPin_b(onReq_b), .powerGoodAlias(pg), .alertLineIn(alertIn),
    .alertLineOut(alertOut), .alertLineOe(alertOe), .redundancyStandbyLineIn(redIn),
    .redundancyStandbyLineOut(redOut), .redundancyStandbyLineOe(redOe), .mainInReg(mainInReg),
    .curLimit(curLimit), .intFail(intFail), .inputOk(inOk), .loadHigh(1'b0), .vinLow(1'b0),
    .plantEvt(plantEvt), .mainEnable(mainEnable), .ledCode(ledCode), .irq(irq));
  psc_host_model host (.ref_clk(ref_clk), .mainEnable(mainEnable), .alertLineOut(alertOut),
    .alertLineOe(alertOe), .redundancyStandbyLineOut(redOut), .redundancyStandbyLineOe(redOe),
    .peerPullLow(extLow), .mainInReg(mainInReg), .alertLine(alertIn), .redundancyStandbyLine(redIn));
  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    if (bvalid !== 1'b1) fails++;
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    if (rvalid !== 1'b1) fails++;
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic waitSig(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    if (s !== v) fails++;
  endtask
  task automatic stop_test;
    if (fails == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // A full run needs about 10000 cycles; the margin covers slow answers.
  initial begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    stop_test();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("redLine", 32'h0, 32'(redIn));
    axr(`PSC_OFS_AMASK);
    chk("alertMask", 32'h0000_0007, d);
    axr(8'h40);
    chk("rresp", 32'h2, 32'(r));
    for (int m = 0; m < 4; m++) begin
      axw(`PSC_OFS_CTRL, 32'(m));
      axr(`PSC_OFS_CTRL);
      chk("mode", 32'(m), d);
    end
    wstrb <= 4'h0;
    axw(`PSC_OFS_CTRL, 32'h0000_0000);
    wstrb <= 4'hF;
    axr(`PSC_OFS_CTRL);
    chk("strbMode", 32'h0000_0003, d);
    axw(`PSC_OFS_CTRL, 32'h0000_0000);
    axw(`PSC_OFS_IMASK, 32'h0000_0001);
    onReq_b <= 1'b0;
    waitSig(mainInReg, 1'b1, 20000);
    chk("mainEnable", 32'h1, 32'(mainEnable));
    t0 = cyc;
    waitSig(pg, 1'b1, 20000);
    chk("pgDelay", 32'h1, 32'(cyc - t0 >= 100 * MSC && cyc - t0 <= 500 * MSC));
    chk("irq", 32'h1, 32'(irq));
    axr(`PSC_OFS_ISTS);
    chk("pgRiseSts", 32'h1, 32'(d[0]));
    axw(`PSC_OFS_ISTS, 32'h0000_0001);
    repeat (2) @(posedge ref_clk);
    chk("irqClear", 32'h0, 32'(irq));
    plantEvt <= 8'h01;
    repeat (6) @(posedge ref_clk);
    chk("alertWarn", 32'h1, 32'(alertOe));
    chk("ledBlink", 32'(LED_ABLINK), 32'(ledCode));
    plantEvt <= 8'h08;
    repeat (6) @(posedge ref_clk);
    chk("alertMasked", 32'h0, 32'(alertOe));
    axw(`PSC_OFS_AMASK, 32'h0000_0008);
    repeat (4) @(posedge ref_clk);
    chk("alertCrit", 32'h1, 32'(alertOe));
    chk("ledAmber", 32'(LED_AMBER), 32'(ledCode));
    plantEvt <= 8'h00;
    onReq_b <= 1'b1;
    t0 = cyc;
    waitSig(pg, 1'b0, 2000);
    chk("pgOffTime", 32'h1, 32'(cyc - t0 <= 50 * MSC));
    t0 = cyc;
    waitSig(mainInReg, 1'b0, 5000);
    chk("pgLead", 32'h1, 32'(cyc - t0 >= MSC && cyc - t0 <= 200 * MSC));
    chk("mainOff", 32'h0, 32'(mainEnable));
    chk("irqMasked", 32'h0, 32'(irq));
    axw(`PSC_OFS_CTRL, 32'h0000_0003);
    curLimit <= 1'b1;
    onReq_b <= 1'b0;
    waitSig(mainInReg, 1'b1, 20000);
    repeat (3000) @(posedge ref_clk);
    chk("pgHeld", 32'h0, 32'(pg));
    curLimit <= 1'b0;
    t0 = cyc;
    waitSig(pg, 1'b1, 20000);
    chk("pgAfterLimit", 32'h1, 32'(cyc - t0 >= 100 * MSC));
    waitSig(mainEnable, 1'b0, 200);
    chk("standbyPg", 32'h1, 32'(pg));
    chk("standbyLed", 32'(LED_GREEN), 32'(ledCode));
    extLow <= 1'b1;
    waitSig(mainEnable, 1'b1, 200);
    chk("wake", 32'h1, 32'(mainEnable));
    waitSig(mainInReg, 1'b1, 200);
    repeat (6) @(posedge ref_clk);
    inOk <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk("pgInLoss", 32'h0, 32'(pg));
    inOk <= 1'b1;
    waitSig(pg, 1'b1, 20000);
    intFail <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk("pgFail", 32'h0, 32'(pg));
    onReq_b <= 1'b1;
    repeat (10) @(posedge ref_clk);
    stop_test();
  end
endmodule // psc_top_tb
`default_nettype wire
